//--- src/logic_tile_pkg.sv
package logic_tile_pkg;

	localparam int NCELL     = 4;
	localparam int NSLICE    = 2;
	localparam int LUT_DEPTH = 16;
	localparam int ADDR_W    = 4;

	// polarity-inversion bit positions within a slice's control word
	localparam int INV_CLK   = 0;
	localparam int INV_CE    = 1;
	localparam int INV_INIT  = 2;
	localparam int INV_OPP   = 3;
	localparam int INV_W     = 4;

	localparam logic [LUT_DEPTH-1:0] MEM_RST  = 16'h0000;
	localparam logic                 REG_RST  = 1'h0;
	localparam logic                 PREV_RST = 1'h0;

	typedef enum logic [1:0] {
		CELL_LOGIC,
		CELL_RAM,
		CELL_SHIFT
	} cell_mode_t;

	typedef enum logic [1:0] {
		RAM_SEP,
		RAM_16X2,
		RAM_32X1,
		RAM_DUAL
	} ram_cfg_t;

	typedef enum logic [1:0] {
		GEN_IN,
		GEN_AND,
		GEN_ZERO,
		GEN_ONE
	} carry_gen_t;

endpackage : logic_tile_pkg

//--- src/logic_tile.sv
`timescale 1ns/1ps
module logic_tile
(
	input  wire logic                                    clk_i,             // system clock
	input  wire logic                                    rst_b_i,           // async reset, low
	// configuration
	input  wire logic                                    cfg_load_i,        // load tables, init
	input  wire logic [3:0][15:0]                        cfg_lut_i,         // table contents
	input  wire logic_tile_pkg::cell_mode_t [3:0]        cfg_mode_i,        // per cell mode
	input  wire logic_tile_pkg::ram_cfg_t [1:0]          cfg_ram_i,         // per slice RAM shape
	input  wire logic_tile_pkg::carry_gen_t [3:0]        cfg_gen_i,         // carry generate source
	input  wire logic [3:0]                              cfg_latch_i,       // 1 = latch
	input  wire logic [3:0]                              cfg_byp_i,         // 1 = bypass input
	input  wire logic [3:0]                              cfg_init_i,        // initial state
	input  wire logic [1:0]                              cfg_async_i,       // async forces
	input  wire logic [1:0][3:0]                         cfg_inv_i,         // control inversion
	// cell inputs
	input  wire logic [3:0][3:0]                         lut_addr_i,        // table inputs
	input  wire logic [3:0]                              ram_di_i,          // RAM / shift data
	input  wire logic [3:0]                              byp_i,             // storage bypass data
	// slice controls
	input  wire logic [1:0]                              slice_clk_i,       // slice clock level
	input  wire logic [1:0]                              slice_ce_i,        // clock enable
	input  wire logic [1:0]                              init_force_i,      // force to init
	input  wire logic [1:0]                              opposite_force_i,  // force to ~init
	input  wire logic [1:0]                              ram_we_i,          // RAM write enable
	input  wire logic [1:0]                              ram_a4_i,          // 32x1 address bit 4
	input  wire logic [1:0]                              f5_sel_i,          // five_input_mux select
	input  wire logic                                    f6_sel_i,          // six_input_mux select
	input  wire logic [1:0]                              cin_i,             // carry in from below
	// drivers and feedthroughs
	input  wire logic [1:0]                              buft_d_i,          // driver data
	input  wire logic [1:0]                              buft_en_i,         // driver enable, high
	input  wire logic [3:0]                              thru_i,            // feedthrough in
	// outputs
	output logic [3:0]                                   lut_o,             // table outputs
	output logic [3:0]                                   reg_o,             // storage outputs
	output logic [3:0]                                   sum_o,             // XOR sum outputs
	output logic [3:0]                                   prod_o,            // AND partial product
	output logic [3:0]                                   shift_o,           // last shift stage
	output logic [1:0]                                   cout_o,            // carry out upward
	output logic [1:0]                                   f5_o,              // five_input_mux out
	output logic                                         f6_o,              // six_input_mux out
	output logic [1:0]                                   bus_o,             // driver data to bus
	output logic [1:0]                                   bus_oe_b_o,        // low while driving
	output logic [3:0]                                   thru_o             // feedthrough out
);
	import logic_tile_pkg::*;

	logic [NCELL-1:0][LUT_DEPTH-1:0] mem_q;
	logic [NCELL-1:0]                reg_q;
	logic [NSLICE-1:0]               prev_q;

	logic [NSLICE-1:0]               lvl;
	logic [NSLICE-1:0]               edge_s;
	logic [NSLICE-1:0]               ce_act;
	logic [NSLICE-1:0]               init_act;
	logic [NSLICE-1:0]               opp_act;
	logic [NSLICE-1:0]               force_any;

	logic [NCELL-1:0][ADDR_W-1:0]    raddr;
	logic [NCELL-1:0][ADDR_W-1:0]    waddr;
	logic [NCELL-1:0]                wdata;
	logic [NCELL-1:0]                wen;
	logic [NCELL-1:0]                lut_val;
	logic [NCELL-1:0]                d_val;
	logic [NCELL-1:0]                sel_val;
	logic [NCELL-1:0]                take;
	logic [NCELL-1:0]                carry;

	function automatic logic active(input logic level, input logic inv);
		active = level ^ inv;
	endfunction : active

	function automatic logic lut_read(input logic [LUT_DEPTH-1:0] tbl,
		input logic [ADDR_W-1:0] a);
		lut_read = tbl[a];
	endfunction : lut_read

	// slice control decode, each control invertible and shared by both cells
	always_comb
	begin
		for (int s = 0; s < NSLICE; s++)
		begin
			lvl[s]       = active(slice_clk_i[s], cfg_inv_i[s][INV_CLK]);
			edge_s[s]    = lvl[s] & ~prev_q[s];
			ce_act[s]    = active(slice_ce_i[s], cfg_inv_i[s][INV_CE]);
			init_act[s]  = active(init_force_i[s], cfg_inv_i[s][INV_INIT]);
			opp_act[s]   = active(opposite_force_i[s], cfg_inv_i[s][INV_OPP]);
			force_any[s] = init_act[s] | opp_act[s];
		end
	end

	// previous clock level for active-edge detection
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			prev_q <= {NSLICE{PREV_RST}};
		else
			prev_q <= lvl;
	end

	// RAM address and data steering per slice shape
	always_comb
	begin
		int f;
		int g;
		f = 0;
		g = 1;
		for (int s = 0; s < NSLICE; s++)
		begin
			f = 2 * s;
			g = 2 * s + 1;
			waddr[f] = lut_addr_i[f];
			waddr[g] = lut_addr_i[g];
			wdata[f] = ram_di_i[f];
			wdata[g] = ram_di_i[g];
			wen[f]   = ram_we_i[s];
			wen[g]   = ram_we_i[s];
			raddr[f] = lut_addr_i[f];
			raddr[g] = lut_addr_i[g];
			case (cfg_ram_i[s])
				RAM_SEP:
				begin
					wen[f] = ram_we_i[s];
				end
				RAM_16X2:
				begin
					waddr[g] = lut_addr_i[f];
					raddr[g] = lut_addr_i[f];
				end
				RAM_32X1:
				begin
					waddr[g] = lut_addr_i[f];
					raddr[g] = lut_addr_i[f];
					wdata[g] = ram_di_i[f];
					wen[f]   = ram_we_i[s] & ~ram_a4_i[s];
					wen[g]   = ram_we_i[s] & ram_a4_i[s];
				end
				RAM_DUAL:
				begin
					waddr[g] = lut_addr_i[f];
					wdata[g] = ram_di_i[f];
				end
				default:
				begin
					wen[f] = ram_we_i[s];
				end
			endcase
		end
		for (int c = 0; c < NCELL; c++)
		begin
			if (cfg_mode_i[c] != CELL_RAM)
			begin
				raddr[c] = lut_addr_i[c];
				wen[c]   = 1'b0;
			end
		end
	end

	// table contents: configuration load, RAM write, shift
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mem_q <= {NCELL{MEM_RST}};
		else
		begin
			for (int c = 0; c < NCELL; c++)
			begin
				if (cfg_load_i)
					mem_q[c] <= cfg_lut_i[c];
				else if (edge_s[c/2])
				begin
					case (cfg_mode_i[c])
						CELL_RAM:
						begin
							if (wen[c])
								mem_q[c][waddr[c]] <= wdata[c];
						end
						CELL_SHIFT:
						begin
							if (ce_act[c/2])
								mem_q[c] <= {mem_q[c][LUT_DEPTH-2:0], ram_di_i[c]};
						end
						default:
						begin
							mem_q[c] <= mem_q[c];
						end
					endcase
				end
			end
		end
	end

	// table read, storage data select and next-state value
	always_comb
	begin
		for (int c = 0; c < NCELL; c++)
		begin
			lut_val[c] = lut_read(mem_q[c], raddr[c]);
			d_val[c]   = cfg_byp_i[c] ? byp_i[c] : lut_val[c];
			if (init_act[c/2])
				sel_val[c] = cfg_init_i[c];
			else if (opp_act[c/2])
				sel_val[c] = ~cfg_init_i[c];
			else if (ce_act[c/2])
				sel_val[c] = d_val[c];
			else
				sel_val[c] = reg_q[c];
			take[c] = cfg_latch_i[c] ? lvl[c/2] : edge_s[c/2];
			if ((cfg_async_i[c/2] & force_any[c/2]) | (cfg_latch_i[c] & lvl[c/2]))
				reg_o[c] = sel_val[c];
			else
				reg_o[c] = reg_q[c];
		end
	end

	// storage elements
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			reg_q <= {NCELL{REG_RST}};
		else
		begin
			for (int c = 0; c < NCELL; c++)
			begin
				if (cfg_load_i)
					reg_q[c] <= cfg_init_i[c];
				else if ((cfg_async_i[c/2] & force_any[c/2]) | take[c])
					reg_q[c] <= sel_val[c];
			end
		end
	end

	// carry chains, one per slice, two bits each
	always_comb
	begin
		logic cin;
		logic gen;
		cin = 1'b0;
		gen = 1'b0;
		for (int c = 0; c < NCELL; c++)
		begin
			cin = (c % 2 == 0) ? cin_i[c/2] : carry[c-1];
			prod_o[c] = lut_addr_i[c][0] & lut_addr_i[c][1];
			case (cfg_gen_i[c])
				GEN_IN:   gen = lut_addr_i[c][0];
				GEN_AND:  gen = prod_o[c];
				GEN_ZERO: gen = 1'b0;
				GEN_ONE:  gen = 1'b1;
				default:  gen = 1'b0;
			endcase
			carry[c] = lut_val[c] ? cin : gen;
			sum_o[c] = lut_val[c] ^ cin;
		end
		cout_o = {carry[3], carry[1]};
	end

	// wide-function multiplexers
	always_comb
	begin
		for (int s = 0; s < NSLICE; s++)
		begin
			if (cfg_mode_i[2*s] == CELL_RAM && cfg_ram_i[s] == RAM_32X1)
				f5_o[s] = ram_a4_i[s] ? lut_val[2*s+1] : lut_val[2*s];
			else
				f5_o[s] = f5_sel_i[s] ? lut_val[2*s+1] : lut_val[2*s];
		end
		f6_o = f6_sel_i ? f5_o[1] : f5_o[0];
	end

	always_comb
	begin
		for (int c = 0; c < NCELL; c++)
			shift_o[c] = mem_q[c][LUT_DEPTH-1];
	end

	assign lut_o      = lut_val;
	assign bus_o      = buft_d_i;
	assign bus_oe_b_o = ~buft_en_i;
	assign thru_o     = thru_i;

endmodule : logic_tile

//--- bench/logic_tile_asserts.sv
`timescale 1ns/1ps
module logic_tile_asserts
	import logic_tile_pkg::*;
(
	input  wire logic            clk_i, rst_b_i, cfg_load_i,
	input  wire logic [3:0]      cfg_latch_i, cfg_byp_i, cfg_init_i, byp_i, thru_i,
	input  wire logic [1:0]      cfg_async_i, slice_clk_i, slice_ce_i, init_force_i,
	input  wire logic [1:0]      opposite_force_i, cin_i, buft_d_i, buft_en_i,
	input  wire logic [1:0][3:0] cfg_inv_i,
	input  wire logic [3:0][3:0] lut_addr_i,
	input  wire logic [3:0]      lut_o, reg_o, sum_o, prod_o, thru_o,
	input  wire logic [1:0]      cout_o, bus_o, bus_oe_b_o
);
	wire  act0 = slice_clk_i[0] ^ cfg_inv_i[0][INV_CLK];
	wire  ce0  = slice_ce_i[0] ^ cfg_inv_i[0][INV_CE];
	wire  in0  = init_force_i[0] ^ cfg_inv_i[0][INV_INIT];
	wire  op0  = opposite_force_i[0] ^ cfg_inv_i[0][INV_OPP];
	wire  d0   = cfg_byp_i[0] ? byp_i[0] : lut_o[0];
	wire  calm = !cfg_load_i && !cfg_async_i[0] && !cfg_latch_i[0];
	logic prev_q;
	// starts high so no edge is seen right after reset
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			prev_q <= 1'h1;
		else
			prev_q <= act0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_edge;
		act0 && !prev_q && calm;
	endsequence
	property p_cap;
		s_edge ##0 (ce0 && !in0 && !op0) |=> (!calm || reg_o[0] == $past(d0));
	endproperty
	a_cap: assert property (p_cap) else $error("flop missed its data");
	property p_init;
		s_edge ##0 in0 |=> (!calm || reg_o[0] == $past(cfg_init_i[0]));
	endproperty
	a_init: assert property (p_init) else $error("init force not taken");
	property p_async;
		cfg_async_i[0] && in0 && !cfg_load_i |-> reg_o[0] == cfg_init_i[0];
	endproperty
	a_async: assert property (p_async) else $error("async force late");
	property p_bus;
		bus_oe_b_o == ~buft_en_i && bus_o == buft_d_i;
	endproperty
	a_bus: assert property (p_bus) else $error("bus driver wrong");
	property p_thru;
		thru_o == thru_i;
	endproperty
	a_thru: assert property (p_thru) else $error("feedthrough wrong");
	property p_prod;
		prod_o[2] == (lut_addr_i[2][0] & lut_addr_i[2][1]);
	endproperty
	a_prod: assert property (p_prod) else $error("product wrong");
	property p_sum;
		sum_o[0] == (lut_o[0] ^ cin_i[0]);
	endproperty
	a_sum: assert property (p_sum) else $error("sum wrong");
	property p_cout;
		&lut_o[1:0] |-> cout_o[0] == cin_i[0];
	endproperty
	a_cout: assert property (p_cout) else $error("carry not passed");
endmodule : logic_tile_asserts
bind logic_tile logic_tile_asserts chk (.*);

//--- bench/logic_tile_partner.sv
`timescale 1ns/1ps
module logic_tile_partner
(
	input  wire logic [1:0] bus_i,  // driver data
	input  wire logic [1:0] oe_b_i, // driver enables, low
	output logic            line_o  // shared bus line
);
	// released line floats to the pull-up
	assign line_o = !oe_b_i[0] ? bus_i[0] : (!oe_b_i[1] ? bus_i[1] : 1'h1);
endmodule : logic_tile_partner

//--- bench/logic_tile_bench.sv
`timescale 1ns/1ps
module logic_tile_bench;
	import logic_tile_pkg::*;
	typedef struct packed {logic [3:0] a; logic [1:0] cin; logic [3:0] lut;} row_t;
	localparam row_t ROWS [5] = '{'{4'h0, 2'h0, 4'h0}, '{4'h9, 2'h3, 4'h3},
		'{4'h6, 2'h1, 4'hC}, '{4'hF, 2'h2, 4'hF}, '{4'h5, 2'h3, 4'h6}};
	logic             clk_i = 1'h0, rst_b_i = 1'h0, cfg_load_i = 1'h0, f6_sel_i = 1'h0;
	logic [3:0][15:0] cfg_lut_i = {16'hCCCC, 16'hF0F0, 16'hAAAA, 16'hFF00};
	cell_mode_t [3:0] cfg_mode_i = '{default: CELL_LOGIC};
	ram_cfg_t [1:0]   cfg_ram_i = '{default: RAM_SEP};
	carry_gen_t [3:0] cfg_gen_i = '{default: GEN_IN};
	logic [3:0]       cfg_latch_i = 4'h0, cfg_byp_i = 4'h0, cfg_init_i = 4'h5, ram_di_i = 4'hF;
	logic [3:0]       byp_i = 4'h0, thru_i = 4'h0, lut_o, reg_o, sum_o, prod_o, shift_o, thru_o;
	logic [1:0][3:0]  cfg_inv_i = 8'h00;
	logic [3:0][3:0]  lut_addr_i = 16'h0000;
	logic [1:0]       cfg_async_i = 2'h0, slice_clk_i = 2'h0, slice_ce_i = 2'h3;
	logic [1:0]       init_force_i = 2'h0, opposite_force_i = 2'h0, ram_we_i = 2'h0;
	logic [1:0]       ram_a4_i = 2'h0, f5_sel_i = 2'h0, cin_i = 2'h0, buft_d_i = 2'h0;
	logic [1:0]       buft_en_i = 2'h0, cout_o, f5_o, bus_o, bus_oe_b_o;
	logic             f6_o, line;
	logic [3:0]       c;
	logic [1:0]       f5x;
	row_t             r;
	int               mismatches = 0, compares = 0, cycles = 0;

	logic_tile dut (.*);
	logic_tile_partner far (.bus_i(bus_o), .oe_b_i(bus_oe_b_o), .line_o(line));

	always #2.5 clk_i = ~clk_i;

	task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic pulse(input int s);
		slice_clk_i[s] = 1'h1;
		@(negedge clk_i);
		slice_clk_i[s] = 1'h0;
		repeat (2) @(negedge clk_i);
	endtask : pulse

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'h1;
		check("reg_rst", reg_o, 4'h0);
		cfg_load_i = 1'h1;
		@(negedge clk_i);
		cfg_load_i = 1'h0;
		check("reg_load", reg_o, 4'h5);
		foreach (ROWS[i])
		begin
			r = ROWS[i];
			lut_addr_i = {4{r.a}};
			{cin_i, f5_sel_i, thru_i} = {r.cin, r.cin, r.a};
			{buft_en_i, buft_d_i, f6_sel_i} = {r.a, r.a[3]};
			@(negedge clk_i);
			c[0] = r.lut[0] ? r.cin[0] : r.a[0];
			c[1] = r.lut[1] ? c[0] : r.a[0];
			c[2] = r.lut[2] ? r.cin[1] : r.a[0];
			c[3] = r.lut[3] ? c[2] : r.a[0];
			f5x[0] = r.cin[0] ? r.lut[1] : r.lut[0];
			f5x[1] = r.cin[1] ? r.lut[3] : r.lut[2];
			check("f5", {2'h0, f5_o}, {2'h0, f5x});
			check("f6", {3'h0, f6_o}, {3'h0, r.a[3] ? f5x[1] : f5x[0]});
			check("lut", lut_o, r.lut);
			check("sum", sum_o, r.lut ^ {c[2], r.cin[1], c[0], r.cin[0]});
			check("prod", prod_o, {4{r.a[0] & r.a[1]}});
			check("cout", {2'h0, cout_o}, {2'h0, c[3], c[1]});
			check("thru", thru_o, r.a);
			check("bus", {bus_oe_b_o, bus_o}, {~r.a[3:2], r.a[1:0]});
			check("line", line, r.a[2] ? r.a[0] : (r.a[3] ? r.a[1] : 1'h1));
		end
		$display("rows done");
		// last row kept: and-gate and zero generate block the carry
		cfg_gen_i = '{GEN_ZERO, GEN_IN, GEN_IN, GEN_AND};
		@(negedge clk_i);
		check("gen0", {2'h0, cout_o}, 4'h0);
		lut_addr_i = 16'h0000;
		cfg_gen_i = '{default: GEN_ONE};
		@(negedge clk_i);
		check("gen1", {2'h0, cout_o}, 4'h3);
		pulse(0);
		check("cap", reg_o, 4'h4);
		{cfg_byp_i, byp_i} = 8'h1F;
		pulse(0);
		check("byp", reg_o, 4'h5);
		{cfg_byp_i, slice_ce_i[0]} = 5'h00;
		pulse(0);
		check("ce_off", reg_o, 4'h5);
		cfg_inv_i[0][INV_CE] = 1'h1;
		pulse(0);
		check("ce_inv", reg_o, 4'h4);
		{cfg_inv_i[0][INV_CE], slice_ce_i[0], init_force_i[0]} = 3'h3;
		repeat (2) @(negedge clk_i);
		check("sync", reg_o, 4'h4);
		pulse(0);
		check("init", reg_o, 4'h5);
		{init_force_i[0], opposite_force_i[0]} = 2'h1;
		pulse(0);
		check("opp", reg_o, 4'h6);
		{opposite_force_i[0], cfg_async_i[0], init_force_i[0]} = 3'h3;
		@(negedge clk_i);
		check("async", reg_o, 4'h5);
		{init_force_i[0], cfg_async_i[0], cfg_latch_i, cfg_byp_i} = 10'h011;
		{byp_i, slice_clk_i[0]} = 5'h01;
		@(negedge clk_i);
		check("open", reg_o, 4'h4);
		byp_i = 4'h1;
		@(negedge clk_i);
		check("follow", reg_o, 4'h5);
		slice_clk_i[0] = 1'h0;
		@(negedge clk_i);
		byp_i = 4'h0;
		@(negedge clk_i);
		check("shut", reg_o, 4'h5);
		{cfg_latch_i, cfg_byp_i, cfg_mode_i[0], lut_addr_i[0]} = {8'h00, CELL_RAM, 4'h3};
		pulse(0);
		check("no_we", lut_o, 4'h0);
		ram_we_i[0] = 1'h1;
		pulse(0);
		check("ram", lut_o, 4'h1);
		// distinct slave data shows which data each shape writes
		{cfg_mode_i[1], ram_di_i[1]} = {CELL_RAM, 1'h0};
		for (int k = 0; k < 2; k++)
		begin
			cfg_ram_i[0] = k ? RAM_DUAL : RAM_16X2;
			lut_addr_i[1:0] = {4'h0, k ? 4'h6 : 4'h5};
			pulse(0);
			lut_addr_i[1] = lut_addr_i[0];
			@(negedge clk_i);
			check("pair", lut_o[1:0], k ? 2'h3 : 2'h1);
		end
		{cfg_ram_i[0], lut_addr_i[0], ram_a4_i[0]} = {RAM_32X1, 4'h2, 1'h1};
		pulse(0);
		ram_we_i[0] = 1'h0;
		check("hi", f5_o[0], 1'h1);
		ram_a4_i[0] = 1'h0;
		@(negedge clk_i);
		check("lo", f5_o[0], 1'h0);
		cfg_mode_i[3] = CELL_SHIFT;
		pulse(1);
		ram_di_i[3] = 1'h0;
		repeat (15) pulse(1);
		{lut_addr_i[3], slice_ce_i[1]} = 5'h1E;
		@(negedge clk_i);
		check("s15", {shift_o[3], lut_o[3]}, 2'h3);
		pulse(1);
		lut_addr_i[3] = 4'hE;
		@(negedge clk_i);
		check("hold", {shift_o[3], lut_o[3]}, 2'h2);
		$display("memory done");
		wrap_up();
	end
endmodule : logic_tile_bench
